//--- rse_pkg.sv
// Constants shared by the ratiometric slider engine: register map, fields, codes, timing.
// Assumes a single 25 MHz device clock.
package rse_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_DATA_TYPE = 8'h7C;
   localparam logic [7:0] ADDR_SETUP = 8'h80;
   localparam logic [7:0] ADDR_RANGE1 = 8'h81;
   localparam logic [7:0] ADDR_RANGE2 = 8'h82;
   localparam logic [7:0] ADDR_STATUS = 8'h83;
   localparam logic [7:0] ADDR_PKT1 = 8'h84;
   localparam logic [7:0] ADDR_PKT2 = 8'h87;
   localparam logic [7:0] ADDR_TOUCH = 8'hB4;
   localparam logic [7:0] ADDR_CHAN_FIRST = 8'hC0;
   localparam logic [7:0] ADDR_CHAN_LAST = 8'hEF;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [23:0] RST_PKT = 24'h000000;
   // Setup register fields
   localparam int SETUP_ON1_BIT = 0;
   localparam int SETUP_WHEEL1_BIT = 2;
   localparam int SETUP_FILT1_BIT = 4;
   localparam int SETUP_PRES_BIT = 6;
   // Channel range register fields
   localparam int RANGE_CNT_LSB = 5;
   localparam int RANGE_START_LSB = 0;
   // Packet fields
   localparam int PKT_POS_LSB = 0;
   localparam int PKT_MOV_LSB = 10;
   localparam int PKT_TS_LSB = 16;
   localparam int PKT_TOUCH_BIT = 23;
   // Channel data view codes
   localparam logic [7:0] VIEW_TOUCH_THR = 8'h01;
   localparam logic [7:0] VIEW_ENV_THR = 8'h02;
   localparam logic [7:0] VIEW_DELAY = 8'h03;
   localparam logic [7:0] VIEW_IMP = 8'h04;
   localparam logic [7:0] VIEW_CAL_IMP = 8'h05;
   localparam logic [7:0] VIEW_LOCKED_IMP = 8'h06;
   // Sizes
   localparam int NUM_CHAN = 24;
   localparam int THR_W = 9;
   localparam int DELAY_W = 6;
   localparam int IMP_W = 13;
   localparam int FIFO_DEPTH = 4;
   localparam int STEPS_PER_CHAN = 128;
   // Timestamp step times and their cycle counts
   localparam int CLK_PERIOD_NS = 40;
   localparam int TS_FAST_STEP_NS = 250_000;
   localparam int TS_SLOW_STEP_NS = 8_000_000;
   localparam int TS_FAST_CYC = TS_FAST_STEP_NS / CLK_PERIOD_NS;
   localparam int TS_SLOW_CYC = TS_SLOW_STEP_NS / CLK_PERIOD_NS;
endpackage

//--- rse_top.sv
// Two ratiometric position engines with the per-channel data views that feed them.
// Assumes a host register port on the device clock and a front end giving one sample strobe per scan.
`timescale 1ns/1ps

// Behaviour
// R01 - Channel is touched when impedance change exceeds its touch threshold; flags readable.
// R02 - Change below environmental threshold recalibrates that channel's reference.
// R03 - Channel delay is a 6-bit value 0 to 63, half picofarad per step.
// R04 - Impedance view is 13 bits, live, falling as capacitance rises.
// R05 - Host drops the low 4 impedance bits by shifting right four.
// R06 - Choosing locked view captures one full impedance set, then freezes it.
// R07 - Engine derives fine position from neighbouring channel capacitance ratio.
// R08 - Host gives each engine a contiguous range of 3 to 8 channels.
// R09 - Host sets range, geometry and filter before enabling an engine.
// R10 - Host clears the engine interrupt bit after reading each data set; the code has no such bit, ratio_irq is a one-cycle pulse.
// R11 - Setup bit 6 set: 8-bit position overwritten in byte one, interrupt on touch.
// R12 - Setup bit 6 clear: packets with position, movement, timestamp are buffered.
// R13 - Setup bits 5 and 4 switch noise filters of engines 2 and 1.
// R14 - Setup bits 3 and 2 pick wheel (one) or slider geometry.
// R15 - Setup bits 1 and 0 enable engines 2 and 1.
// R16 - Range bits 7 to 5 hold channel count minus one.
// R17 - Range bits 4 to 0 hold the first channel number.
// R18 - Status bits 1 and 0 flag multi-touch on engines 2 and 1.
// R19 - Each engine presents a 3-byte packet at 0x84 or 0x87, four deep.
// R20 - Data type selects touch, environment, delay, impedance, calibrated or locked view.
// R21 - Packet bit 23 shows finger presence; interrupt on release.
// R22 - Timestamp counts steps of 8 ms with median filter, else quarter milliseconds.
// R23 - Movement is current minus previous position; byte one holds low position bits.
// R24 - Full buffer drops new packets; disabled engine makes no packets or interrupts.
// R25 - Reading a packet's last byte advances to the next stored packet, if any.
module rse_top
   import rse_pkg::*;
#(
   parameter int TS_FAST_CYCLES = TS_FAST_CYC,
   parameter int TS_SLOW_CYCLES = TS_SLOW_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic sample_valid,
   input wire logic [NUM_CHAN-1:0][IMP_W-1:0] chan_impedance,
   input wire logic median_filter,
   output logic [NUM_CHAN-1:0][DELAY_W-1:0] channel_delay,
   output logic [NUM_CHAN-1:0] realtime_touch_flags,
   output logic ratio_irq,
   output logic [9:0] eng1_position_out,
   output logic [9:0] eng2_position_out
);

   // Channel number at offset i from the first channel, wrapped at the channel count
   function automatic logic [4:0] chan_at(input logic [4:0] first, input logic [2:0] i);
      logic [5:0] s;
      s = {1'b0, first} + {3'b000, i};
      if (s >= 6'(NUM_CHAN)) begin
         s = s - 6'(NUM_CHAN);
      end
      return s[4:0];
   endfunction

   // Byte b of a 24-bit word
   function automatic logic [7:0] pick(input logic [23:0] w, input logic [1:0] b);
      return w[8*b +: 8];
   endfunction

   logic [7:0] setup, next_setup;
   logic [7:0] eng_range [2];
   logic [7:0] next_eng_range [2];
   logic [7:0] data_type, next_data_type;
   logic [7:0] next_reg_rdata;
   logic [THR_W-1:0] touch_thr [NUM_CHAN];
   logic [THR_W-1:0] next_touch_thr [NUM_CHAN];
   logic [THR_W-1:0] env_thr [NUM_CHAN];
   logic [THR_W-1:0] next_env_thr [NUM_CHAN];
   logic [NUM_CHAN-1:0][DELAY_W-1:0] next_delay;
   logic [IMP_W-1:0] cal_imp [NUM_CHAN];
   logic [IMP_W-1:0] next_cal_imp [NUM_CHAN];
   logic [IMP_W-1:0] lock_imp [NUM_CHAN];
   logic [IMP_W-1:0] next_lock_imp [NUM_CHAN];
   logic [NUM_CHAN-1:0] next_touch;
   logic lock_pend, next_lock_pend;
   logic [IMP_W-1:0] delta [NUM_CHAN];
   logic [IMP_W-1:0] diff;
   logic [23:0] eng_view [2];
   logic eng_mt [2];
   logic eng_irq [2];
   logic [9:0] eng_pos [2];
   logic pop [2];
   logic chan_hit;
   logic [4:0] chan_sel;
   logic [15:0] chan_word;

   assign chan_hit = (reg_addr >= ADDR_CHAN_FIRST) && (reg_addr <= ADDR_CHAN_LAST);
   assign chan_sel = 5'((reg_addr - ADDR_CHAN_FIRST) >> 1);
   assign ratio_irq = eng_irq[0] | eng_irq[1];
   assign eng1_position_out = eng_pos[0];
   assign eng2_position_out = eng_pos[1];
   assign pop[0] = reg_rd && (reg_addr == ADDR_PKT1 + 8'h02); // R25
   assign pop[1] = reg_rd && (reg_addr == ADDR_PKT2 + 8'h02); // R25

   // Impedance drop against the reference, as seen by the engines
   always_comb begin
      for (int c = 0; c < NUM_CHAN; c++) begin
         delta[c] = (cal_imp[c] > chan_impedance[c]) ? cal_imp[c] - chan_impedance[c] : '0;
      end
   end

   // Channel views: thresholds, delay, calibration, lock, touch flags
   always_comb begin
      next_touch_thr = touch_thr;
      next_env_thr = env_thr;
      next_delay = channel_delay;
      next_cal_imp = cal_imp;
      next_lock_imp = lock_imp;
      next_touch = realtime_touch_flags;
      next_lock_pend = lock_pend;
      diff = '0;
      if (sample_valid) begin
         for (int c = 0; c < NUM_CHAN; c++) begin
            diff = (chan_impedance[c] > cal_imp[c]) ? chan_impedance[c] - cal_imp[c]
                                                    : cal_imp[c] - chan_impedance[c];
            next_touch[c] = {4'h0, diff} > {4'h0, touch_thr[c]}; // R01
            if ({4'h0, diff} < {4'h0, env_thr[c]}) begin
               next_cal_imp[c] = chan_impedance[c]; // R02
            end
            if (lock_pend) begin
               next_lock_imp[c] = chan_impedance[c]; // R06
            end
         end
         next_lock_pend = 1'b0;
      end
      // Selecting the locked view arms one full capture
      if (reg_wr && reg_addr == ADDR_DATA_TYPE && reg_wdata == VIEW_LOCKED_IMP) begin
         next_lock_pend = 1'b1; // R06
      end
      // Host writes reach only the writable views
      if (reg_wr && chan_hit) begin
         if (data_type == VIEW_TOUCH_THR) begin
            if (reg_addr[0]) next_touch_thr[chan_sel][8] = reg_wdata[0];
            else next_touch_thr[chan_sel][7:0] = reg_wdata;
         end
         if (data_type == VIEW_ENV_THR) begin
            if (reg_addr[0]) next_env_thr[chan_sel][8] = reg_wdata[0];
            else next_env_thr[chan_sel][7:0] = reg_wdata;
         end
         if (data_type == VIEW_DELAY && !reg_addr[0]) begin
            next_delay[chan_sel] = reg_wdata[DELAY_W-1:0]; // R03
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int c = 0; c < NUM_CHAN; c++) begin
            touch_thr[c] <= '0;
            env_thr[c] <= '0;
            channel_delay[c] <= '0;
            cal_imp[c] <= '0;
            lock_imp[c] <= '0;
         end
         realtime_touch_flags <= '0;
         lock_pend <= 1'b0;
      end else begin
         touch_thr <= next_touch_thr;
         env_thr <= next_env_thr;
         channel_delay <= next_delay;
         cal_imp <= next_cal_imp;
         lock_imp <= next_lock_imp;
         realtime_touch_flags <= next_touch;
         lock_pend <= next_lock_pend;
      end
   end

   // Selected channel view word
   always_comb begin
      unique case (data_type)
         VIEW_TOUCH_THR: chan_word = {7'h00, touch_thr[chan_sel]}; // R20
         VIEW_ENV_THR: chan_word = {7'h00, env_thr[chan_sel]};
         VIEW_DELAY: chan_word = {10'h000, channel_delay[chan_sel]};
         VIEW_IMP: chan_word = {3'h0, chan_impedance[chan_sel]}; // R04
         VIEW_CAL_IMP: chan_word = {3'h0, cal_imp[chan_sel]};
         VIEW_LOCKED_IMP: chan_word = {3'h0, lock_imp[chan_sel]};
         default: chan_word = 16'h0000;
      endcase
   end

   // Setup registers and registered read data
   always_comb begin
      next_setup = setup;
      next_eng_range = eng_range;
      next_data_type = data_type;
      next_reg_rdata = reg_rdata;
      if (reg_wr) begin
         unique case (reg_addr)
            ADDR_SETUP: next_setup = reg_wdata; // R15
            ADDR_RANGE1: next_eng_range[0] = reg_wdata; // R16
            ADDR_RANGE2: next_eng_range[1] = reg_wdata; // R17
            ADDR_DATA_TYPE: next_data_type = reg_wdata;
            default: ;
         endcase
      end
      if (reg_rd) begin
         next_reg_rdata = 8'h00;
         if (chan_hit) begin
            next_reg_rdata = reg_addr[0] ? chan_word[15:8] : chan_word[7:0];
         end
         unique case (reg_addr)
            ADDR_SETUP: next_reg_rdata = setup;
            ADDR_RANGE1: next_reg_rdata = eng_range[0];
            ADDR_RANGE2: next_reg_rdata = eng_range[1];
            ADDR_STATUS: next_reg_rdata = {6'h00, eng_mt[1], eng_mt[0]}; // R18
            ADDR_DATA_TYPE: next_reg_rdata = data_type;
            ADDR_PKT1, ADDR_PKT1 + 8'h01, ADDR_PKT1 + 8'h02:
               next_reg_rdata = pick(eng_view[0], 2'(reg_addr - ADDR_PKT1)); // R19
            ADDR_PKT2, ADDR_PKT2 + 8'h01, ADDR_PKT2 + 8'h02:
               next_reg_rdata = pick(eng_view[1], 2'(reg_addr - ADDR_PKT2)); // R19
            ADDR_TOUCH, ADDR_TOUCH + 8'h01, ADDR_TOUCH + 8'h02:
               next_reg_rdata = pick(realtime_touch_flags, 2'(reg_addr - ADDR_TOUCH)); // R01
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         setup <= RST_BYTE;
         eng_range[0] <= RST_BYTE;
         eng_range[1] <= RST_BYTE;
         data_type <= RST_BYTE;
         reg_rdata <= RST_BYTE;
      end else begin
         setup <= next_setup;
         eng_range <= next_eng_range;
         data_type <= next_data_type;
         reg_rdata <= next_reg_rdata;
      end
   end

   // One position engine per slider or wheel
   for (genvar e = 0; e < 2; e++) begin : g_eng
      logic on, wheel, filt, pres;
      logic [2:0] cnt_m1;
      logic [4:0] first;
      logic [23:0] fifo [FIFO_DEPTH];
      logic [23:0] next_fifo [FIFO_DEPTH];
      logic [1:0] wp, next_wp, rp, next_rp;
      logic [2:0] cnt, next_cnt;
      logic [23:0] last_pkt, next_last_pkt;
      logic [9:0] pos, next_pos, pos_out;
      logic was_touch, next_was_touch, touch_now, any_t;
      logic mt, next_mt, irq, next_irq;
      logic [17:0] tick, next_tick, tick_lim;
      logic [6:0] ts, next_ts;
      logic [2:0] k;
      logic [IMP_W-1:0] dk, dp, dn;
      logic signed [21:0] num, den, q;
      logic signed [11:0] pos_s, span;
      logic [5:0] movement_field;

      assign on = setup[SETUP_ON1_BIT + e]; // R15
      assign wheel = setup[SETUP_WHEEL1_BIT + e]; // R14
      assign filt = setup[SETUP_FILT1_BIT + e]; // R13
      assign pres = setup[SETUP_PRES_BIT];
      assign cnt_m1 = eng_range[e][RANGE_CNT_LSB +: 3]; // R16
      assign first = eng_range[e][RANGE_START_LSB +: 5]; // R17
      assign eng_view[e] = (!pres && cnt != 3'd0) ? fifo[rp] : last_pkt;
      assign eng_mt[e] = mt;
      assign eng_irq[e] = irq;
      assign eng_pos[e] = pos;

      always_comb begin
         next_fifo = fifo;
         next_wp = wp;
         next_rp = rp;
         next_cnt = cnt;
         next_last_pkt = last_pkt;
         next_pos = pos;
         next_was_touch = was_touch;
         next_mt = mt;
         next_irq = 1'b0;
         next_tick = tick;
         next_ts = ts;
         // Strongest channel in the range, and any touch in it
         k = 3'd0;
         dk = '0;
         any_t = 1'b0;
         for (int i = 0; i < 8; i++) begin
            if (3'(i) <= cnt_m1) begin
               if (delta[chan_at(first, 3'(i))] > dk) begin
                  dk = delta[chan_at(first, 3'(i))];
                  k = 3'(i);
               end
               any_t = any_t | realtime_touch_flags[chan_at(first, 3'(i))];
            end
         end
         // Neighbours; a wheel wraps around, a slider ends in nothing
         dp = (k != 3'd0) ? delta[chan_at(first, k - 3'd1)] : (wheel ? delta[chan_at(first, cnt_m1)] : '0);
         dn = (k != cnt_m1) ? delta[chan_at(first, k + 3'd1)] : (wheel ? delta[chan_at(first, 3'd0)] : '0);
         // Fine step from the neighbour ratio
         num = ($signed({9'h000, dn}) - $signed({9'h000, dp})) <<< 6; // R07
         den = $signed({9'h000, dk}) + 22'sd1;
         q = num / den;
         span = $signed({1'b0, {1'b0, cnt_m1} + 4'd1, 7'h00});
         pos_s = $signed({2'b00, k, 7'h00}) + 12'sd64 + 12'(q);
         if (wheel) begin
            if (pos_s < 12'sd0) pos_s = pos_s + span; // R14
            else if (pos_s >= span) pos_s = pos_s - span;
         end else begin
            if (pos_s < 12'sd0) pos_s = 12'sd0;
            else if (pos_s >= span) pos_s = span - 12'sd1;
         end
         // Optional smoothing against the last position
         pos_out = 10'(pos_s);
         if (filt && was_touch) begin
            pos_out = 10'(({1'b0, pos} + {1'b0, 10'(pos_s)}) >> 1); // R13
         end
         touch_now = on && any_t;
         // Timestamp ticks, step picked by the median filter
         tick_lim = median_filter ? 18'(TS_SLOW_CYCLES - 1) : 18'(TS_FAST_CYCLES - 1); // R22
         if (tick >= tick_lim) begin
            next_tick = '0;
            if (ts != 7'h7F) next_ts = ts + 7'd1;
         end else begin
            next_tick = tick + 18'd1;
         end
         // Reading the last byte moves to the next stored packet
         if (pop[e] && !pres && cnt != 3'd0) begin
            next_last_pkt = fifo[rp]; // R25
            next_rp = rp + 2'd1;
            next_cnt = next_cnt - 3'd1;
         end
         movement_field = '0;
         if (sample_valid && on && (touch_now || was_touch)) begin // R24
            if (!touch_now) begin
               pos_out = pos;
            end else if (was_touch) begin
               movement_field = 6'(pos_out - pos); // R23
            end
            next_mt = 1'b0;
            for (int i = 0; i < 8; i++) begin
               if (3'(i) <= cnt_m1 && realtime_touch_flags[chan_at(first, 3'(i))]
                   && (3'(i) > k + 3'd1 || k > 3'(i) + 3'd1)) begin
                  next_mt = 1'b1; // R18
               end
            end
            if (pres) begin
               next_last_pkt = {16'h0000, pos_out[9:2]}; // R11
               next_irq = touch_now; // R11
            end else begin
               if (cnt < 3'(FIFO_DEPTH)) begin // R24
                  next_fifo[wp] = {touch_now, ts, movement_field, pos_out}; // R12
                  next_wp = wp + 2'd1;
                  next_cnt = next_cnt + 3'd1;
                  next_irq = 1'b1;
               end
               if (!touch_now) next_irq = 1'b1; // R21
               next_ts = '0;
               next_tick = '0;
            end
            next_pos = pos_out;
         end
         if (sample_valid) begin
            next_was_touch = touch_now;
            if (!touch_now) next_mt = 1'b0;
         end
      end

      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            for (int i = 0; i < FIFO_DEPTH; i++) fifo[i] <= RST_PKT;
            wp <= '0;
            rp <= '0;
            cnt <= '0;
            last_pkt <= RST_PKT;
            pos <= '0;
            was_touch <= 1'b0;
            mt <= 1'b0;
            irq <= 1'b0;
            tick <= '0;
            ts <= '0;
         end else begin
            fifo <= next_fifo;
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
            last_pkt <= next_last_pkt;
            pos <= next_pos;
            was_touch <= next_was_touch;
            mt <= next_mt;
            irq <= next_irq;
            tick <= next_tick;
            ts <= next_ts;
         end
      end
   end

endmodule // rse_top

//--- rse_top_chk.sv
// Port checker for the ratiometric slider engine block.
// Assumes one clock and async active-high reset; bound to rse_top.
`timescale 1ns/1ps
module rse_top_chk
   import rse_pkg::*;
#(
   parameter int TS_FAST_CYCLES = 4,
   parameter int TS_SLOW_CYCLES = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic sample_valid,
   input wire logic [NUM_CHAN-1:0][DELAY_W-1:0] channel_delay,
   input wire logic [NUM_CHAN-1:0] realtime_touch_flags,
   input wire logic ratio_irq,
   input wire logic [9:0] eng1_position_out,
   input wire logic [9:0] eng2_position_out
);
   logic [7:0] setup_shadow;
   logic [7:0] next_setup_shadow;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Expected setup contents from observed writes
   always_comb begin
      next_setup_shadow = setup_shadow;
      if (reg_wr && reg_addr == ADDR_SETUP) begin
         next_setup_shadow = reg_wdata;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         setup_shadow <= RST_BYTE;
      end else begin
         setup_shadow <= next_setup_shadow;
      end
   end
   sequence range_wr_s;
      reg_wr && reg_addr == ADDR_RANGE2;
   endsequence
   sequence range_rd_s;
      reg_rd && !reg_wr && reg_addr == ADDR_RANGE2;
   endsequence
   irq_after_scan_a: assert property (ratio_irq |-> $past(sample_valid))
      else $error("irq without preceding scan");
   pos_after_scan_a: assert property ($changed(eng1_position_out) || $changed(eng2_position_out) |-> $past(sample_valid))
      else $error("position moved without scan");
   flags_after_scan_a: assert property ($changed(realtime_touch_flags) |-> $past(sample_valid))
      else $error("touch flags moved without scan");
   delay_by_write_a: assert property ($changed(channel_delay) |-> $past(reg_wr))
      else $error("delay moved without write");
   status_reserved_a: assert property (reg_rd && reg_addr == ADDR_STATUS |=> reg_rdata[7:2] == 6'h00)
      else $error("status reserved bits set");
   unmapped_zero_a: assert property (reg_rd && reg_addr < ADDR_DATA_TYPE |=> reg_rdata == RST_BYTE)
      else $error("unmapped read not zero");
   setup_readback_a: assert property (reg_rd && !reg_wr && reg_addr == ADDR_SETUP |=> reg_rdata == $past(setup_shadow))
      else $error("setup readback wrong");
   range_readback_a: assert property (range_wr_s ##1 !reg_wr ##1 range_rd_s |=> reg_rdata == $past(reg_wdata, 3))
      else $error("range readback wrong");
   rdata_by_read_a: assert property ($changed(reg_rdata) |-> $past(reg_rd))
      else $error("read data moved without read");
endmodule // rse_top_chk

//--- rse_front_model.sv
// Front-end model: live impedance per channel and scan strobes.
// Assumes the device clock; resting level 0x64 on every channel.
`timescale 1ns/1ps
module rse_front_model
   import rse_pkg::*;
(
   input wire logic clk,
   output logic sample_valid,
   output logic [NUM_CHAN-1:0][IMP_W-1:0] chan_impedance,
   output logic median_filter
);
   // Idle levels
   initial begin
      sample_valid = 1'b0;
      median_filter = 1'b0;
      for (int c = 0; c < NUM_CHAN; c++) begin
         chan_impedance[c] = 13'h0064;
      end
   end
   // One scan of channels 0 to 2, then an idle gap
   task automatic scan(input logic [IMP_W-1:0] i0, i1, i2);
      @(posedge clk);
      chan_impedance[0] <= i0;
      chan_impedance[1] <= i1;
      chan_impedance[2] <= i2;
      sample_valid <= 1'b1;
      @(posedge clk);
      sample_valid <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
endmodule // rse_front_model

//--- ratiometric_slider_engine_test.sv
// Register-level testbench for rse_top with front-end model.
// Assumes rse_pkg, rse_top_chk and rse_front_model compiled first.
`timescale 1ns/1ps
module ratiometric_slider_engine_test;
   import rse_pkg::*;
   logic clk, rst, reg_wr, reg_rd, sample_valid, median_filter, ratio_irq;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, b;
   logic [NUM_CHAN-1:0][IMP_W-1:0] chan_impedance;
   logic [NUM_CHAN-1:0][DELAY_W-1:0] channel_delay;
   logic [NUM_CHAN-1:0] realtime_touch_flags;
   logic [9:0] eng1_position_out, eng2_position_out;
   logic [23:0] p;
   int n_errors = 0;
   int n_compared = 0;
   int n_irq = 0;
   rse_top #(.TS_FAST_CYCLES(4), .TS_SLOW_CYCLES(16)) i_rse_top (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sample_valid(sample_valid), .chan_impedance(chan_impedance), .median_filter(median_filter),
      .channel_delay(channel_delay), .realtime_touch_flags(realtime_touch_flags), .ratio_irq(ratio_irq),
      .eng1_position_out(eng1_position_out), .eng2_position_out(eng2_position_out));
   rse_front_model i_rse_front_model (.clk(clk), .sample_valid(sample_valid),
      .chan_impedance(chan_impedance), .median_filter(median_filter));
   // Clock and interrupt pulse counter
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) if (ratio_irq === 1'b1) n_irq++;
   // Comparisons
   task automatic cmp8(input string s, input logic [7:0] e, g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic cmp24(input string s, input logic [23:0] e, g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", s, e, g);
      end
   endtask
   // Register port cycles
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic rc(input logic [7:0] a, e, input string s);
      rd(a, b);
      cmp8(s, e, b);
   endtask
   task automatic ch_wr(input int c, input logic [8:0] v);
      logic [7:0] a;
      a = ADDR_CHAN_FIRST + 8'(2 * c);
      wr(a, v[7:0]);
      wr(a + 8'h01, {7'h00, v[8]});
   endtask
   task automatic pkt(input logic [7:0] a);
      rd(a, p[7:0]);
      rd(a + 8'h01, p[15:8]);
      rd(a + 8'h02, p[23:16]);
   endtask
   task automatic end_of_test();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence
   initial begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rc(ADDR_SETUP, RST_BYTE, "setup reset");
      rc(ADDR_RANGE1, RST_BYTE, "range1 reset");
      rc(ADDR_PKT1, RST_BYTE, "packet reset");
      rc(8'h70, RST_BYTE, "unmapped");
      wr(ADDR_SETUP, 8'h3C);
      rc(ADDR_SETUP, 8'h3C, "setup");
      wr(ADDR_RANGE2, 8'hE5);
      rc(ADDR_RANGE2, 8'hE5, "range2");
      wr(ADDR_STATUS, 8'hFF);
      rc(ADDR_STATUS, 8'h00, "status");
      wr(ADDR_SETUP, 8'h00);
      // Delay view at its top value
      wr(ADDR_DATA_TYPE, VIEW_DELAY);
      wr(8'hCA, 8'hFF);
      rc(8'hCA, 8'h3F, "delay readback");
      cmp8("delay out", 8'h3F, {2'b00, channel_delay[5]});
      // Calibrate every channel to rest, then set thresholds
      wr(ADDR_DATA_TYPE, VIEW_ENV_THR);
      for (int c = 0; c < NUM_CHAN; c++) ch_wr(c, 9'h1FF);
      i_rse_front_model.scan(13'd100, 13'd100, 13'd100);
      for (int c = 0; c < NUM_CHAN; c++) ch_wr(c, 9'h00A);
      wr(ADDR_DATA_TYPE, VIEW_TOUCH_THR);
      for (int c = 0; c < NUM_CHAN; c++) ch_wr(c, 9'h014);
      i_rse_front_model.scan(13'd100, 13'd100, 13'd100);
      cmp24("flags rest", 24'h000000, realtime_touch_flags);
      wr(ADDR_DATA_TYPE, VIEW_CAL_IMP);
      rc(8'hC0, 8'h64, "calibrated");
      // Lock, then touch channel 1
      wr(ADDR_DATA_TYPE, VIEW_LOCKED_IMP);
      i_rse_front_model.scan(13'd100, 13'd100, 13'd100);
      i_rse_front_model.scan(13'd100, 13'd50, 13'd100);
      rc(8'hC2, 8'h64, "locked");
      wr(ADDR_DATA_TYPE, VIEW_IMP);
      rc(8'hC2, 8'h32, "live");
      rd(8'hC3, p[15:8]);
      cmp8("usable imp", 8'h03, 8'({p[15:8], b} >> 4));
      cmp24("flags touch", 24'h000002, realtime_touch_flags);
      // Buffered packets: three channels from 0, buffer overfilled
      wr(ADDR_RANGE1, 8'h40);
      wr(ADDR_SETUP, 8'h01);
      n_irq = 0;
      i_rse_front_model.scan(13'd100, 13'd50, 13'd100);
      repeat (2) i_rse_front_model.scan(13'd100, 13'd50, 13'd68);
      i_rse_front_model.median_filter <= 1'b1;
      i_rse_front_model.scan(13'd100, 13'd50, 13'd68);
      repeat (2) i_rse_front_model.scan(13'd100, 13'd50, 13'd52);
      cmp8("irq count", 8'd4, 8'(n_irq));
      rc(ADDR_STATUS, 8'h00, "multitouch");
      pkt(ADDR_PKT1);
      cmp24("packet 1", 24'h8000C0, {p[23], 7'h00, p[15:0]});
      pkt(ADDR_PKT1);
      cmp8("packet 2 touch", 8'h01, {7'h00, p[23]});
      pkt(ADDR_PKT1);
      cmp24("packet 3", 24'h8100E8, {p[23:16], 6'h00, p[9:0]});
      pkt(ADDR_PKT1);
      cmp24("packet 4", 24'h8000E8, {p[23], 7'h00, p[15:0]});
      cmp8("packet 4 stamp", 8'h80, p[23:16]);
      pkt(ADDR_PKT1);
      cmp24("packet held", 24'h8000E8, {p[23], 7'h00, p[15:0]});
      // Presentation mode
      wr(ADDR_SETUP, 8'h41);
      n_irq = 0;
      repeat (2) i_rse_front_model.scan(13'd100, 13'd50, 13'd100);
      cmp8("irq present", 8'd2, 8'(n_irq));
      rc(ADDR_PKT1, 8'h30, "present pos");
      rc(ADDR_PKT1 + 8'h01, 8'h00, "present mid");
      cmp24("position out", 24'd192, {14'h0000, eng1_position_out});
      // Disabled engine stays silent
      wr(ADDR_SETUP, 8'h00);
      n_irq = 0;
      repeat (2) i_rse_front_model.scan(13'd100, 13'd100, 13'd100);
      cmp8("irq disabled", 8'd0, 8'(n_irq));
      cmp24("position 2", 24'd0, {14'h0000, eng2_position_out});
      end_of_test();
   end
endmodule // ratiometric_slider_engine_test
bind rse_top rse_top_chk #(.TS_FAST_CYCLES(TS_FAST_CYCLES), .TS_SLOW_CYCLES(TS_SLOW_CYCLES)) i_rse_top_chk (
   .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .sample_valid(sample_valid), .channel_delay(channel_delay),
   .realtime_touch_flags(realtime_touch_flags), .ratio_irq(ratio_irq),
   .eng1_position_out(eng1_position_out), .eng2_position_out(eng2_position_out));
